// ===== shared/swap_defines.svh
// Constants for the express-swap request framer.
`ifndef SWAP_DEFINES_SVH
`define SWAP_DEFINES_SVH

`define HDR_NEXT        8'hF2
`define HDR_LATER       8'hF3
`define HDR_MATCH       7'h79
`define CRC_POLY        16'h9001
`define CRC_INIT        16'h0000
`define SYM_LAST        4'hF
`define MAX_TONES       12'h020
`define NIB_HDR         3'h2
`define NIB_CNT         3'h3
`define NIB_TONE        3'h5
`define NIB_DUMMY       3'h1
`define NIB_CRC         3'h4

`endif

// ===== shared/swap_pkg.sv
// Types shared by the express-swap request framer.
package swap_pkg;

  typedef struct packed {
    logic [11:0] idx;
    logic [3:0]  bits;
    logic [3:0]  gain;
  } tone_t;

  typedef struct packed {
    logic        late;
    logic [11:0] count;
  } swap_req_t;

  typedef enum logic [5:0] {
    TX_IDLE  = 6'h01,
    TX_HDR   = 6'h02,
    TX_CNT   = 6'h04,
    TX_TONE  = 6'h08,
    TX_DUMMY = 6'h10,
    TX_CRC   = 6'h20
  } tx_state_t;

  typedef enum logic [6:0] {
    RX_HDR   = 7'h01,
    RX_CNT   = 7'h02,
    RX_TONE  = 7'h04,
    RX_DUMMY = 7'h08,
    RX_CRC   = 7'h10,
    RX_WAIT  = 7'h20,
    RX_APPLY = 7'h40
  } rx_state_t;

  typedef enum logic [2:0] {
    W_IDLE  = 3'h1,
    W_WAIT  = 3'h2,
    W_WATCH = 3'h4
  } watch_state_t;

endpackage

// ===== logic/express_swap_framer.sv
// Express-swap request builder, parser and frame scheduler.
`timescale 1ns/10ps
`default_nettype none
`include "swap_defines.svh"

// Function
// - A detected SNR change while idle starts one express-swap request over the overhead control channel.
// - Each request is sent exactly once and never repeated by the block.
// - The header is F2 for the next bit-swap frame and F3 for the one after.
// - The message is header, tone count, n tone fields, dummy bits, then the check value.
// - A 12-bit tone count follows the header.
// - Each tone field is a 12-bit sub-channel index followed by the loading and gain byte.
// - The upper nibble of that byte is the new absolute bit count, 0 to 15.
// - The lower nibble is a signed half-decibel gain from -4 dB to +3.5 dB.
// - Four dummy bits follow the last tone field when n is even, none when n is odd.
// - A 16-bit cyclic check over all command bits is appended on send and checked on receipt.
// - The check uses generator terms 16, 15, 12 and 0, one bit per step, MSB first.
// - With no acknowledge, the requester watches the expected frame and reports a miss.
// - A bit-swap frame is 16 symbols and the scheduling timer counts such frames.
// - Bit-swap frames are counted modulo 256.
// - Sub-channel indices rise with frequency from zero at the lowest sub-carrier.
module express_swap_framer (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              sym_tick,
  input  wire logic              snr_change,
  input  wire swap_pkg::swap_req_t req_cfg,
  input  wire logic              tone_valid,
  output logic                   tone_ready,
  input  wire swap_pkg::tone_t   tone_in,
  output logic [7:0]             tx_byte,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  input  wire logic              swap_seen,
  output logic                   req_busy,
  output logic                   swap_ok,
  output logic                   swap_missed,
  input  wire logic [7:0]        rx_byte,
  input  wire logic              rx_valid,
  output logic                   rx_ready,
  output logic                   crc_err,
  output logic                   upd_valid,
  output swap_pkg::tone_t        upd_tone,
  output logic [7:0]             frame_cnt
);

  // **********************************************************
  // Frame timing
  // **********************************************************
  logic [3:0] sym_cnt_r;
  logic [7:0] frame_cnt_r;
  logic       frame_end;

  assign frame_end = sym_tick && (sym_cnt_r == `SYM_LAST);
  assign frame_cnt = frame_cnt_r;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sym_cnt_r   <= 4'h0;
      frame_cnt_r <= 8'h00;
    end else if (sym_tick) begin
      sym_cnt_r <= sym_cnt_r + 4'h1;
      if (frame_end) begin
        frame_cnt_r <= frame_cnt_r + 8'h01;
      end
    end
  end

  function automatic logic [15:0] crc_nib(input logic [15:0] c, input logic [3:0] n);
    logic [15:0] r;
    r = c;
    for (int i = 3; i >= 0; i--) begin
      if (r[15] ^ n[i]) begin
        r = {r[14:0], 1'b0} ^ `CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  // **********************************************************
  // Request builder
  // **********************************************************
  swap_pkg::tx_state_t tx_st_r;
  logic [19:0] sh_r;
  logic [2:0]  left_r;
  logic [11:0] tleft_r;
  logic [11:0] tcount_r;
  logic        late_r;
  logic [15:0] tcrc_r;
  logic [3:0]  hi_r;
  logic        half_r;
  logic [7:0]  tx_byte_r;
  logic        tx_valid_r;
  logic        emit;
  logic        sent;

  assign emit = (left_r != 3'h0) && (!tx_valid_r || tx_ready);
  assign tone_ready = ((tx_st_r == swap_pkg::TX_CNT) || (tx_st_r == swap_pkg::TX_TONE)) &&
                      (left_r == 3'h0) && (tleft_r != 12'h000);
  assign sent = (tx_st_r == swap_pkg::TX_CRC) && (left_r == 3'h0);
  assign req_busy = (tx_st_r != swap_pkg::TX_IDLE);
  assign tx_byte = tx_byte_r;
  assign tx_valid = tx_valid_r;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tx_st_r  <= swap_pkg::TX_IDLE;
      sh_r     <= 20'h00000;
      left_r   <= 3'h0;
      tleft_r  <= 12'h000;
      tcount_r <= 12'h000;
      late_r   <= 1'b0;
    end else if (emit) begin
      sh_r   <= {sh_r[15:0], 4'h0};
      left_r <= left_r - 3'h1;
    end else if (left_r == 3'h0) begin
      unique case (tx_st_r)
        swap_pkg::TX_IDLE: begin
          // taken only when idle, sent once
          if (snr_change) begin
            tcount_r <= req_cfg.count;
            late_r   <= req_cfg.late;
            sh_r     <= {(req_cfg.late ? `HDR_LATER : `HDR_NEXT), 12'h000};
            left_r   <= `NIB_HDR;
            tx_st_r  <= swap_pkg::TX_HDR;
          end
        end
        swap_pkg::TX_HDR: begin
          sh_r    <= {tcount_r, 8'h00};
          left_r  <= `NIB_CNT;
          tleft_r <= tcount_r;
          tx_st_r <= swap_pkg::TX_CNT;
        end
        swap_pkg::TX_CNT, swap_pkg::TX_TONE: begin
          if (tleft_r != 12'h000) begin
            // index then loading and gain byte
            if (tone_valid) begin
              sh_r    <= tone_in;
              left_r  <= `NIB_TONE;
              tleft_r <= tleft_r - 12'h001;
              tx_st_r <= swap_pkg::TX_TONE;
            end
          end else if (!tcount_r[0]) begin
            sh_r    <= 20'h00000;
            left_r  <= `NIB_DUMMY;
            tx_st_r <= swap_pkg::TX_DUMMY;
          end else begin
            sh_r    <= {tcrc_r, 4'h0};
            left_r  <= `NIB_CRC;
            tx_st_r <= swap_pkg::TX_CRC;
          end
        end
        swap_pkg::TX_DUMMY: begin
          sh_r    <= {tcrc_r, 4'h0};
          left_r  <= `NIB_CRC;
          tx_st_r <= swap_pkg::TX_CRC;
        end
        swap_pkg::TX_CRC: begin
          tx_st_r <= swap_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // check value over every bit before it
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tcrc_r <= `CRC_INIT;
    end else if (tx_st_r == swap_pkg::TX_IDLE) begin
      tcrc_r <= `CRC_INIT;
    end else if (emit && (tx_st_r != swap_pkg::TX_CRC)) begin
      tcrc_r <= crc_nib(tcrc_r, sh_r[19:16]);
    end
  end

  // Nibbles pair into bytes high nibble first; every message is a whole number of bytes.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hi_r       <= 4'h0;
      half_r     <= 1'b0;
      tx_byte_r  <= 8'h00;
      tx_valid_r <= 1'b0;
    end else begin
      if (tx_valid_r && tx_ready) begin
        tx_valid_r <= 1'b0;
      end
      if (emit) begin
        half_r <= !half_r;
        if (!half_r) begin
          hi_r <= sh_r[19:16];
        end else begin
          tx_byte_r  <= {hi_r, sh_r[19:16]};
          tx_valid_r <= 1'b1;
        end
      end
    end
  end

  // **********************************************************
  // Outcome watch
  // **********************************************************
  swap_pkg::watch_state_t w_st_r;
  logic [7:0] wtarget_r;
  logic       seen_r;
  logic       ok_r;
  logic       miss_r;

  assign swap_ok = ok_r;
  assign swap_missed = miss_r;

  // no acknowledge, so the returned signal is checked on the expected frame
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      w_st_r    <= swap_pkg::W_IDLE;
      wtarget_r <= 8'h00;
      seen_r    <= 1'b0;
      ok_r      <= 1'b0;
      miss_r    <= 1'b0;
    end else begin
      ok_r   <= 1'b0;
      miss_r <= 1'b0;
      unique case (w_st_r)
        swap_pkg::W_IDLE: begin
          if (sent) begin
            wtarget_r <= frame_cnt_r + (late_r ? 8'h02 : 8'h01);
            w_st_r    <= swap_pkg::W_WAIT;
          end
        end
        swap_pkg::W_WAIT: begin
          if (frame_end && (frame_cnt_r + 8'h01 == wtarget_r)) begin
            seen_r <= 1'b0;
            w_st_r <= swap_pkg::W_WATCH;
          end
        end
        swap_pkg::W_WATCH: begin
          if (frame_end) begin
            ok_r   <= seen_r || swap_seen;
            miss_r <= !(seen_r || swap_seen);
            w_st_r <= swap_pkg::W_IDLE;
          end else if (swap_seen) begin
            seen_r <= 1'b1;
          end
        end
      endcase
    end
  end

  // **********************************************************
  // Request parser
  // **********************************************************
  swap_pkg::rx_state_t rx_st_r;
  swap_pkg::tone_t mem [0:`MAX_TONES-1];
  logic [3:0]  rlow_r;
  logic        rpend_r;
  logic [15:0] racc_r;
  logic [2:0]  rleft_r;
  logic [11:0] rcount_r;
  logic [11:0] widx_r;
  logic        ovf_r;
  logic        rlate_r;
  logic [15:0] rcrc_r;
  logic [7:0]  rtarget_r;
  logic        crc_err_r;
  logic        upd_valid_r;
  swap_pkg::tone_t upd_tone_r;
  logic        rn_v;
  logic [3:0]  rn;
  logic        parsing;
  logic        last;
  logic [15:0] crc_base;

  assign parsing = !(rx_st_r inside {swap_pkg::RX_WAIT, swap_pkg::RX_APPLY});
  assign rx_ready = parsing && !rpend_r;
  assign rn_v = rpend_r || (rx_valid && rx_ready);
  assign rn = rpend_r ? rlow_r : rx_byte[7:4];
  assign last = rn_v && (rleft_r == 3'h1);
  assign crc_base = ((rx_st_r == swap_pkg::RX_HDR) && (rleft_r == `NIB_HDR)) ? `CRC_INIT : rcrc_r;
  assign crc_err = crc_err_r;
  assign upd_valid = upd_valid_r;
  assign upd_tone = upd_tone_r;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rpend_r <= 1'b0;
      rlow_r  <= 4'h0;
    end else if (rpend_r) begin
      rpend_r <= 1'b0;
    end else if (rx_valid && rx_ready) begin
      rpend_r <= 1'b1;
      rlow_r  <= rx_byte[3:0];
    end
  end

  // receiver recomputes the check over the command bits
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rcrc_r <= `CRC_INIT;
    end else if (rn_v && (rx_st_r != swap_pkg::RX_CRC)) begin
      rcrc_r <= crc_nib(crc_base, rn);
    end
  end

  // indices are stored as sent, lowest sub-carrier at zero
  always_ff @(posedge mclk) begin
    if (last && (rx_st_r == swap_pkg::RX_TONE) && (widx_r < `MAX_TONES)) begin
      mem[widx_r[4:0]] <= {racc_r, rn};
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rx_st_r     <= swap_pkg::RX_HDR;
      racc_r      <= 16'h0000;
      rleft_r     <= `NIB_HDR;
      rcount_r    <= 12'h000;
      widx_r      <= 12'h000;
      ovf_r       <= 1'b0;
      rlate_r     <= 1'b0;
      rtarget_r   <= 8'h00;
      crc_err_r   <= 1'b0;
      upd_valid_r <= 1'b0;
      upd_tone_r  <= '0;
    end else begin
      crc_err_r   <= 1'b0;
      upd_valid_r <= 1'b0;
      if (rn_v) begin
        racc_r  <= {racc_r[11:0], rn};
        rleft_r <= rleft_r - 3'h1;
      end
      unique case (rx_st_r)
        swap_pkg::RX_HDR: begin
          if (last) begin
            // only the two express headers are accepted
            if ({racc_r[3:0], rn[3:1]} == `HDR_MATCH) begin
              rlate_r <= rn[0];
              rleft_r <= `NIB_CNT;
              rx_st_r <= swap_pkg::RX_CNT;
            end else begin
              rleft_r <= `NIB_HDR;
            end
          end
        end
        swap_pkg::RX_CNT: begin
          if (last) begin
            rcount_r <= {racc_r[7:0], rn};
            ovf_r    <= ({racc_r[7:0], rn} > `MAX_TONES);
            widx_r   <= 12'h000;
            if ({racc_r[7:0], rn} == 12'h000) begin
              rleft_r <= `NIB_DUMMY;
              rx_st_r <= swap_pkg::RX_DUMMY;
            end else begin
              rleft_r <= `NIB_TONE;
              rx_st_r <= swap_pkg::RX_TONE;
            end
          end
        end
        swap_pkg::RX_TONE: begin
          if (last) begin
            widx_r <= widx_r + 12'h001;
            if (widx_r + 12'h001 != rcount_r) begin
              rleft_r <= `NIB_TONE;
            end else if (!rcount_r[0]) begin
              // even n carries a dummy nibble
              rleft_r <= `NIB_DUMMY;
              rx_st_r <= swap_pkg::RX_DUMMY;
            end else begin
              rleft_r <= `NIB_CRC;
              rx_st_r <= swap_pkg::RX_CRC;
            end
          end
        end
        swap_pkg::RX_DUMMY: begin
          if (last) begin
            rleft_r <= `NIB_CRC;
            rx_st_r <= swap_pkg::RX_CRC;
          end
        end
        swap_pkg::RX_CRC: begin
          if (last) begin
            rleft_r <= `NIB_HDR;
            if (({racc_r[11:0], rn} == rcrc_r) && !ovf_r) begin
              rtarget_r <= frame_cnt_r + (rlate_r ? 8'h02 : 8'h01);
              rx_st_r   <= swap_pkg::RX_WAIT;
            end else begin
              crc_err_r <= 1'b1;
              rx_st_r   <= swap_pkg::RX_HDR;
            end
          end
        end
        swap_pkg::RX_WAIT: begin
          // tables change at the start of the target frame
          if (frame_end && (frame_cnt_r + 8'h01 == rtarget_r)) begin
            widx_r  <= 12'h000;
            rx_st_r <= swap_pkg::RX_APPLY;
          end
        end
        swap_pkg::RX_APPLY: begin
          upd_valid_r <= 1'b1;
          upd_tone_r  <= mem[widx_r[4:0]];
          widx_r      <= widx_r + 12'h001;
          if (widx_r + 12'h001 == rcount_r) begin
            rx_st_r <= swap_pkg::RX_HDR;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== verif/express_swap_framer_checker.sv
// Port-level checks for the express-swap framer.
`timescale 1ns/10ps
`default_nettype none
module express_swap_framer_checker (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       sym_tick,
  input wire logic       snr_change,
  input wire logic       tone_ready,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       req_busy,
  input wire logic       swap_ok,
  input wire logic       swap_missed,
  input wire logic       crc_err,
  input wire logic       upd_valid,
  input wire logic [7:0] frame_cnt
);
  logic [3:0] tk_r;
  logic       fend;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Symbol phase kept here so frame ends are judged independently.
  always_ff @(posedge mclk) begin
    if (!nrst)
      tk_r <= 4'h0;
    else if (sym_tick)
      tk_r <= tk_r + 4'h1;
  end
  assign fend = sym_tick && tk_r == 4'hF;
  chk_req_start: assert property (
    snr_change && !req_busy |=> req_busy ##[1:4] tx_valid)
    else $error("request did not start");
  chk_no_repeat: assert property (
    $rose(req_busy) |-> $past(snr_change))
    else $error("request started on its own");
  chk_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("byte changed before accept");
  chk_tone_pull: assert property (
    tone_ready |-> req_busy)
    else $error("tone pulled while idle");
  chk_frame_len: assert property (
    fend |=> frame_cnt == $past(frame_cnt) + 8'h01)
    else $error("frame end missed");
  chk_frame_only: assert property (
    $past(nrst) && frame_cnt != $past(frame_cnt) |-> $past(fend))
    else $error("frame count moved early");
  chk_frame_wrap: assert property (
    $past(nrst) && frame_cnt != $past(frame_cnt) |-> frame_cnt == $past(frame_cnt) + 8'h01)
    else $error("frame count jumped");
  chk_watch_edge: assert property (
    swap_ok || swap_missed |-> frame_cnt != $past(frame_cnt))
    else $error("verdict off a frame end");
  chk_one_verdict: assert property (
    swap_ok || swap_missed |-> !(swap_ok && swap_missed) ##1 !swap_ok && !swap_missed)
    else $error("verdict not a single pulse");
  chk_bad_drop: assert property (
    crc_err |-> !upd_valid [*8])
    else $error("rejected request updated table");
endmodule
bind express_swap_framer express_swap_framer_checker chk_u (
  .mclk, .nrst, .sym_tick, .snr_change, .tone_ready, .tx_byte, .tx_valid, .tx_ready,
  .req_busy, .swap_ok, .swap_missed, .crc_err, .upd_valid, .frame_cnt);
`default_nettype wire

// ===== verif/far_end_model.sv
// Far-end modem byte link: sinks sent bytes and sources received ones.
`timescale 1ns/10ps
`default_nettype none
module far_end_model (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       slow,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  input  wire logic       rx_ready
);
  logic [7:0] got[$];
  logic [7:0] snd[$];
  int         ph = 0;
  initial begin
    tx_ready = 1'h1;
    rx_valid = 1'h0;
    rx_byte  = 8'h00;
  end
  always @(posedge mclk) begin
    if (nrst && tx_valid && tx_ready)
      got.push_back(tx_byte);
    if (rx_valid && rx_ready)
      void'(snd.pop_front());
    #1;
    ph++;
    tx_ready = !slow || ph % 4 == 0;
    rx_valid = snd.size() > 0;
    // Idle line toggles so a stale byte never passes for a fresh one.
    rx_byte = rx_valid ? snd[0] : ~rx_byte;
  end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the express-swap framer.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic              mclk = 1'h0;
  logic              nrst = 1'h0;
  logic              sym_tick = 1'h0;
  logic              snr_change = 1'h0;
  logic              tone_valid = 1'h0;
  logic              swap_seen = 1'h0;
  logic              slow = 1'h0;
  logic              tone_ready, tx_valid, tx_ready, req_busy, swap_ok, swap_missed;
  logic              rx_valid, rx_ready, crc_err, upd_valid;
  logic [7:0]        tx_byte, rx_byte, frame_cnt;
  swap_pkg::swap_req_t req_cfg = 13'h0000;
  swap_pkg::tone_t   tone_in = 20'h00000;
  swap_pkg::tone_t   upd_tone;
  swap_pkg::tone_t   tl[3] = '{20'hFFFF8, 20'h00007, 20'h1232F};
  swap_pkg::tone_t   tq[$], fq[$], uq[$];
  logic [3:0]        nib[$];
  logic [7:0]        eb[$];
  int                n_fail = 0;
  int                n_tests = 0;
  int                sc = 0;
  int                ce = 0;
  express_swap_framer dut_u (
    .mclk, .nrst, .sym_tick, .snr_change, .req_cfg, .tone_valid, .tone_ready,
    .tone_in, .tx_byte, .tx_valid, .tx_ready, .swap_seen, .req_busy, .swap_ok,
    .swap_missed, .rx_byte, .rx_valid, .rx_ready, .crc_err, .upd_valid, .upd_tone,
    .frame_cnt);
  far_end_model fe_u (
    .mclk, .nrst, .slow, .tx_byte, .tx_valid, .tx_ready, .rx_byte, .rx_valid, .rx_ready);
  initial begin
    forever #5 mclk = ~mclk;
  end
  // A symbol every 4 cycles keeps frames short enough to reach the count wrap.
  always @(posedge mclk) begin
    if (tone_valid && tone_ready)
      void'(fq.pop_front());
    if (nrst && upd_valid)
      uq.push_back(upd_tone);
    if (nrst && crc_err)
      ce++;
    #1;
    sc++;
    sym_tick = sc % 4 == 0;
    tone_valid = fq.size() > 0;
    if (tone_valid)
      tone_in = fq[0];
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_t(input swap_pkg::tone_t g, input swap_pkg::tone_t e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected tone at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic put(input logic [19:0] v, input int k);
    for (int i = k - 1; i >= 0; i--)
      nib.push_back(v[4 * i +: 4]);
  endtask
  task automatic build(input logic lt);
    logic [15:0] c;
    nib.delete();
    eb.delete();
    put({12'h000, 7'h79, lt}, 2);
    put({8'h00, 12'(tq.size())}, 3);
    foreach (tq[i])
      put(tq[i], 5);
    if (tq.size() % 2 == 0)
      put(20'h00000, 1);
    c = 16'h0000;
    foreach (nib[i])
      for (int j = 3; j >= 0; j--)
        c = {c[14:0], 1'h0} ^ ((c[15] ^ nib[i][j]) ? 16'h9001 : 16'h0000);
    put({4'h0, c}, 4);
    for (int i = 0; i < nib.size(); i += 2)
      eb.push_back({nib[i], nib[i + 1]});
  endtask
  task automatic t_tx(input logic lt, input int n, input logic see, input logic sl);
    logic [7:0] f0;
    int         k;
    tq.delete();
    for (k = 0; k < n; k++)
      tq.push_back(tl[k]);
    build(lt);
    fq = tq;
    slow = sl;
    fe_u.got.delete();
    req_cfg = {lt, 12'(n)};
    snr_change = 1'h1;
    tick(1);
    snr_change = 1'h0;
    tick(4);
    snr_change = 1'h1;
    tick(1);
    snr_change = 1'h0;
    for (k = 0; k < 400 && req_busy; k++)
      tick(1);
    f0 = frame_cnt;
    swap_seen = see;
    for (k = 0; k < 400 && !(swap_ok || swap_missed); k++)
      tick(1);
    swap_seen = 1'h0;
    cmp({7'h00, swap_ok}, {7'h00, see});
    cmp({7'h00, swap_missed}, {7'h00, !see});
    cmp(frame_cnt - f0, lt ? 8'h03 : 8'h02);
    for (k = 0; k < 400 && fe_u.got.size() < eb.size(); k++)
      tick(1);
    tick(40);
    cmp(8'(fe_u.got.size()), 8'(eb.size()));
    foreach (eb[i])
      cmp(fe_u.got[i], eb[i]);
  endtask
  task automatic t_rx(input logic bad);
    int k;
    tq = {tl[0], tl[2]};
    build(1'h1);
    if (bad)
      eb[eb.size() - 1] ^= 8'h01;
    uq.delete();
    ce = 0;
    fe_u.snd = {8'h55, eb};
    for (k = 0; k < 600 && uq.size() < 2 && ce == 0; k++)
      tick(1);
    tick(100);
    cmp(8'(ce), {7'h00, bad});
    cmp(8'(uq.size()), bad ? 8'h00 : 8'h02);
    foreach (uq[i])
      cmp_t(uq[i], tq[i]);
  endtask
  task automatic t_wrap();
    int k;
    for (k = 0; k < 20000 && frame_cnt !== 8'hFF; k++)
      tick(1);
    for (k = 0; k < 100 && frame_cnt === 8'hFF; k++)
      tick(1);
    cmp(frame_cnt, 8'h00);
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    end_of_test();
  end
  initial begin
    tick(2);
    nrst = 1'h1;
    t_tx(1'h0, 0, 1'h1, 1'h0);
    t_tx(1'h1, 3, 1'h0, 1'h1);
    t_tx(1'h0, 2, 1'h1, 1'h1);
    t_rx(1'h0);
    t_rx(1'h1);
    t_wrap();
    end_of_test();
  end
endmodule
`default_nettype wire
